// ===== rtl/tap_defs.vh
`ifndef TAP_DEFS_VH
`define TAP_DEFS_VH

// Controller state codes (standard boundary-scan graph)
`define ST_RESET 4'hF
`define ST_IDLE 4'hC
`define ST_SEL_DR 4'h7
`define ST_CAP_DR 4'h6
`define ST_SHF_DR 4'h2
`define ST_EX1_DR 4'h1
`define ST_PAU_DR 4'h3
`define ST_EX2_DR 4'h0
`define ST_UPD_DR 4'h5
`define ST_SEL_IR 4'h4
`define ST_CAP_IR 4'hE
`define ST_SHF_IR 4'hA
`define ST_EX1_IR 4'h9
`define ST_PAU_IR 4'hB
`define ST_EX2_IR 4'h8
`define ST_UPD_IR 4'hD

// Instruction codes and widths
`define IR_W 3
`define INS_EXTEST 3'h0
`define INS_IDCODE 3'h1
`define INS_SAMPLEZ 3'h2
`define INS_SAMPLE 3'h4
`define INS_BYPASS 3'h7
`define IR_CAPTURE 3'h1
`define ID_W 32
`define BSR_W 70

// Output FIFO geometry
`define FIFO_W 1
`define FIFO_D 8

`endif

// ===== rtl/bit_fifo.v
`timescale 1ns/100ps
`include "tap_defs.vh"

module bit_fifo #(
    parameter WIDTH = `FIFO_W,
    parameter DEPTH = `FIFO_D,
    parameter AW = 3
) (
    // Clock and reset
    input wire clk,
    input wire resetn,
    input wire flush,
    // Fill side
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    // Drain side
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);

reg [WIDTH-1:0] mem_r [0:DEPTH-1];
reg [AW-1:0] wp_r;
reg [AW-1:0] rp_r;
reg [AW:0] cnt_r;
wire push;
wire pop;
integer i;

// Honest full and empty from the occupancy count
assign in_ready = (cnt_r != DEPTH[AW:0]);
assign out_valid = (cnt_r != {(AW+1){1'b0}});
assign out_data = mem_r[rp_r];
assign push = in_valid && in_ready;
assign pop = out_valid && out_ready;

////////////////////////////////////////////////////////////////////////////////
// Storage and pointers; flush drops everything queued
always @(posedge clk or negedge resetn)
begin
    if (!resetn)
    begin
        wp_r <= {AW{1'b0}};
        rp_r <= {AW{1'b0}};
        cnt_r <= {(AW+1){1'b0}};
        for (i = 0; i < DEPTH; i = i + 1)
            mem_r[i] <= {WIDTH{1'b0}};
    end
    else if (flush)
    begin
        wp_r <= {AW{1'b0}};
        rp_r <= {AW{1'b0}};
        cnt_r <= {(AW+1){1'b0}};
    end
    else
    begin
        if (push)
        begin
            mem_r[wp_r] <= in_data;
            wp_r <= (wp_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_r + 1'b1;
        end
        if (pop)
            rp_r <= (rp_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_r + 1'b1;
        if (push && !pop)
            cnt_r <= cnt_r + 1'b1;
        else if (pop && !push)
            cnt_r <= cnt_r - 1'b1;
    end
end

endmodule

// ===== rtl/tap_ctrl.v
`timescale 1ns/100ps
`include "tap_defs.vh"

// Summary of operation
// - Sixteen-state controller steers test registers
// - State steps on test clock rise, mode-select chooses
// - Power-up lands in test-logic-reset state
// - Five ones on mode-select force reset
// - Serial input sampled only in shift states
// - Serial output driven only in shift states
// - Reset loads identification instruction into register
// - Bypass captures zero, shifts one bit
// - Sample captures ring, outputs unchanged
// - Sample-Z captures ring, floats data outputs
module tap_ctrl #(
    parameter ID_VALUE = 32'h0000_0001, // Arbitrary identification value
    parameter BSR_LEN = `BSR_W
) (
    // System clock and reset
    input wire clk,
    input wire resetn,
    // Test port pins, asynchronous to clk
    input wire tck,
    input wire tms,
    input wire tdi,
    output reg tdo,
    output reg tdo_oe,
    // I/O ring levels to capture
    input wire [BSR_LEN-1:0] ring_in,
    // Data output control and status
    output reg dq_hiz_force,
    output reg [3:0] tap_state,
    output reg [`IR_W-1:0] ir_active
);

////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers: two flops before any logic looks at the pins
reg [1:0] tck_s_r;
reg [1:0] tms_s_r;
reg [1:0] tdi_s_r;
reg tck_d_r;
wire tck_rise;

always @(posedge clk or negedge resetn)
begin
    if (!resetn)
    begin
        tck_s_r <= 2'h0;
        tms_s_r <= 2'h0;
        tdi_s_r <= 2'h0;
        tck_d_r <= 1'b0;
    end
    else
    begin
        tck_s_r <= {tck_s_r[0], tck};
        tms_s_r <= {tms_s_r[0], tms};
        tdi_s_r <= {tdi_s_r[0], tdi};
        tck_d_r <= tck_s_r[1];
    end
end

// One-cycle enable on each rising test clock edge
assign tck_rise = tck_s_r[1] && !tck_d_r;

////////////////////////////////////////////////////////////////////////////////
// Next-state graph
reg [3:0] st_r;
reg [3:0] st_nxt;

always @*
begin
    st_nxt = st_r;
    case (st_r)
        `ST_RESET: st_nxt = tms_s_r[1] ? `ST_RESET : `ST_IDLE;
        `ST_IDLE: st_nxt = tms_s_r[1] ? `ST_SEL_DR : `ST_IDLE;
        `ST_SEL_DR: st_nxt = tms_s_r[1] ? `ST_SEL_IR : `ST_CAP_DR;
        `ST_CAP_DR: st_nxt = tms_s_r[1] ? `ST_EX1_DR : `ST_SHF_DR;
        `ST_SHF_DR: st_nxt = tms_s_r[1] ? `ST_EX1_DR : `ST_SHF_DR;
        `ST_EX1_DR: st_nxt = tms_s_r[1] ? `ST_UPD_DR : `ST_PAU_DR;
        `ST_PAU_DR: st_nxt = tms_s_r[1] ? `ST_EX2_DR : `ST_PAU_DR;
        `ST_EX2_DR: st_nxt = tms_s_r[1] ? `ST_UPD_DR : `ST_SHF_DR;
        `ST_UPD_DR: st_nxt = tms_s_r[1] ? `ST_SEL_DR : `ST_IDLE;
        `ST_SEL_IR: st_nxt = tms_s_r[1] ? `ST_RESET : `ST_CAP_IR;
        `ST_CAP_IR: st_nxt = tms_s_r[1] ? `ST_EX1_IR : `ST_SHF_IR;
        `ST_SHF_IR: st_nxt = tms_s_r[1] ? `ST_EX1_IR : `ST_SHF_IR;
        `ST_EX1_IR: st_nxt = tms_s_r[1] ? `ST_UPD_IR : `ST_PAU_IR;
        `ST_PAU_IR: st_nxt = tms_s_r[1] ? `ST_EX2_IR : `ST_PAU_IR;
        `ST_EX2_IR: st_nxt = tms_s_r[1] ? `ST_UPD_IR : `ST_SHF_IR;
        `ST_UPD_IR: st_nxt = tms_s_r[1] ? `ST_SEL_DR : `ST_IDLE;
        default: st_nxt = `ST_RESET;
    endcase
end

// State register; moves only on a test clock rise
always @(posedge clk or negedge resetn)
begin
    if (!resetn)
        st_r <= `ST_RESET;
    else if (tck_rise)
        st_r <= st_nxt;
end

////////////////////////////////////////////////////////////////////////////////
// Instruction, bypass, identification and boundary registers
reg [`IR_W-1:0] ir_sh_r;
reg [`IR_W-1:0] ir_r;
reg byp_r;
reg [`ID_W-1:0] id_r;
reg [BSR_LEN-1:0] bsr_r;
reg [BSR_LEN-1:0] ring_s1_r;
reg [BSR_LEN-1:0] ring_s2_r;
wire in_shift;
wire sel_bsr;

assign in_shift = (st_r == `ST_SHF_DR) || (st_r == `ST_SHF_IR);
assign sel_bsr = (ir_r == `INS_SAMPLE) || (ir_r == `INS_SAMPLEZ) || (ir_r == `INS_EXTEST);

// Ring levels come from another domain, so they are synchronised too
always @(posedge clk or negedge resetn)
begin
    if (!resetn)
    begin
        ring_s1_r <= {BSR_LEN{1'b0}};
        ring_s2_r <= {BSR_LEN{1'b0}};
    end
    else
    begin
        ring_s1_r <= ring_in;
        ring_s2_r <= ring_s1_r;
    end
end

// Capture, shift and update; the serial input is read in shift states only
always @(posedge clk or negedge resetn)
begin
    if (!resetn)
    begin
        ir_sh_r <= `IR_CAPTURE;
        ir_r <= `INS_IDCODE;
        byp_r <= 1'b0;
        id_r <= ID_VALUE;
        bsr_r <= {BSR_LEN{1'b0}};
    end
    else if (tck_rise)
    begin
        case (st_r)
            `ST_RESET:
                ir_r <= `INS_IDCODE;
            `ST_CAP_IR:
                ir_sh_r <= `IR_CAPTURE;
            `ST_SHF_IR:
                ir_sh_r <= {tdi_s_r[1], ir_sh_r[`IR_W-1:1]};
            `ST_UPD_IR:
                ir_r <= ir_sh_r;
            `ST_CAP_DR:
            begin
                if (ir_r == `INS_IDCODE)
                    id_r <= ID_VALUE;
                else if (sel_bsr)
                    bsr_r <= ring_s2_r;
                else
                    byp_r <= 1'b0;
            end
            `ST_SHF_DR:
            begin
                if (ir_r == `INS_IDCODE)
                    id_r <= {tdi_s_r[1], id_r[`ID_W-1:1]};
                else if (sel_bsr)
                    bsr_r <= {tdi_s_r[1], bsr_r[BSR_LEN-1:1]};
                else
                    byp_r <= tdi_s_r[1];
            end
            default:
                ir_r <= ir_r;
        endcase
        // Entering the reset state restores the id instruction at once, so a
        // sample-Z float cannot outlive a forced reset by a test clock
        if (st_nxt == `ST_RESET)
            ir_r <= `INS_IDCODE;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Output bits queue in a FIFO; the pin side drains one per falling-edge slot
reg tck_fall_r;
reg sel_bit;
wire fifo_in_ready;
wire fifo_out_valid;
wire [`FIFO_W-1:0] fifo_out;

always @*
begin
    if (st_r == `ST_SHF_IR)
        sel_bit = ir_sh_r[0];
    else if (ir_r == `INS_IDCODE)
        sel_bit = id_r[0];
    else if (sel_bsr)
        sel_bit = bsr_r[0];
    else
        sel_bit = byp_r;
end

// Falling edge of the test clock launches the next output bit
always @(posedge clk or negedge resetn)
begin
    if (!resetn)
        tck_fall_r <= 1'b0;
    else
        tck_fall_r <= !tck_s_r[1] && tck_d_r;
end

// Queue a bit at each rise while in a shift state; a bit is dropped, not held, if the pin side lags, and leaving shift flushes what is queued
bit_fifo #(
    .WIDTH(`FIFO_W),
    .DEPTH(`FIFO_D),
    .AW(3)
) u_fifo (
    .clk(clk),
    .resetn(resetn),
    .flush(!in_shift),
    .in_valid(tck_rise && in_shift),
    .in_ready(fifo_in_ready),
    .in_data(sel_bit),
    .out_valid(fifo_out_valid),
    .out_ready(tck_fall_r),
    .out_data(fifo_out)
);

// Pin drivers and status; the data outputs float under the sample-Z instruction
always @(posedge clk or negedge resetn)
begin
    if (!resetn)
    begin
        tdo <= 1'b0;
        tdo_oe <= 1'b0;
        dq_hiz_force <= 1'b0;
        tap_state <= `ST_RESET;
        ir_active <= `INS_IDCODE;
    end
    else
    begin
        tdo_oe <= in_shift;
        if (!in_shift)
            tdo <= 1'b0;
        else if (tck_fall_r && fifo_out_valid)
            tdo <= fifo_out[0];
        else if (!fifo_out_valid && fifo_in_ready)
            tdo <= sel_bit;
        dq_hiz_force <= (ir_r == `INS_SAMPLEZ);
        tap_state <= st_r;
        ir_active <= ir_r;
    end
end

endmodule

// ===== bench/tap_checker.sv
`timescale 1ns/100ps
`include "tap_defs.vh"

module tap_checker (
    // Clocks
    input wire clk,
    input wire resetn,
    // Pins
    input wire tck,
    input wire tms,
    input wire tdo,
    input wire tdo_oe,
    // Status
    input wire dq_hiz_force,
    input wire [3:0] tap_state,
    input wire [2:0] ir_active
);
    reg tck_r;
    reg [3:0] age_r;
    reg [2:0] ones_r;
    wire shf = tap_state == `ST_SHF_DR || tap_state == `ST_SHF_IR;
    wire rise = tck && !tck_r;
    // Cycles since a test clock rise, and run of ones; both saturate
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            tck_r <= 1'h0;
            age_r <= 4'hF;
            ones_r <= 3'h0;
        end
        else
        begin
            tck_r <= tck;
            age_r <= rise ? 4'h0 : age_r + {3'h0, age_r != 4'hF};
            if (rise)
                ones_r <= tms ? ones_r + {2'h0, ones_r < 3'h5} : 3'h0;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    step_rise_a: assert property ($changed(tap_state) |-> age_r >= 4'h2 && age_r <= 4'h6)
        else $error("state moved off a test clock rise");
    five_ones_a: assert property (ones_r == 3'h5 && age_r == 4'h6 |-> tap_state == `ST_RESET)
        else $error("five ones did not reset");
    oe_rise_a: assert property ($rose(tdo_oe) |-> ##[0:2] shf)
        else $error("output enabled outside shift");
    oe_fall_a: assert property ($fell(tdo_oe) |-> ##[0:2] !shf)
        else $error("output dropped inside shift");
    tdo_quiet_a: assert property ((!shf)[*4] |-> !tdo)
        else $error("serial out active outside shift");
    reset_vals_a: assert property ($rose(resetn) |->
        tap_state == `ST_RESET && ir_active == `INS_IDCODE && !tdo_oe)
        else $error("bad values after reset");
    reset_ir_a: assert property ((tap_state == `ST_RESET)[*3] |-> ir_active == `INS_IDCODE)
        else $error("reset state without id instruction");
    hiz_on_a: assert property ((ir_active == `INS_SAMPLEZ)[*2] |-> dq_hiz_force)
        else $error("outputs not floated");
    hiz_off_a: assert property ((ir_active != `INS_SAMPLEZ)[*2] |-> !dq_hiz_force)
        else $error("outputs floated wrongly");
    tlr_exit_a: assert property ($changed(tap_state) && $past(tap_state) == `ST_RESET
        |-> tap_state == `ST_IDLE)
        else $error("bad exit from reset state");
    shift_exit_a: assert property ($changed(tap_state) && $past(tap_state) == `ST_SHF_DR
        |-> tap_state == `ST_EX1_DR)
        else $error("bad exit from data shift");
endmodule

bind tap_ctrl tap_checker u_chk (.clk(clk), .resetn(resetn), .tck(tck), .tms(tms),
    .tdo(tdo), .tdo_oe(tdo_oe), .dq_hiz_force(dq_hiz_force), .tap_state(tap_state),
    .ir_active(ir_active));

// ===== bench/jtag_tester.sv
`timescale 1ns/100ps

module jtag_tester (
    // Pacing clock
    input wire clk,
    // Pins
    output reg tck,
    output reg tms,
    output reg tdi,
    input wire tdo
);
    integer half = 4;
    // One test clock; tdo is taken two cycles into the high phase, before the
    // block has seen the rise, since its output lags the pin edges by the sync delay
    task step(input logic m, input logic d, output logic q);
    begin
        tms = m;
        tdi = d;
        repeat (half) @(negedge clk);
        tck = 1'h1;
        repeat (2) @(negedge clk);
        q = tdo;
        repeat (half - 2) @(negedge clk);
        tck = 1'h0;
    end
    endtask
    // Clock stands still between frames
    initial
    begin
        tck = 1'h0;
        tms = 1'h1;
        tdi = 1'h0;
    end
endmodule

// ===== bench/tb.sv
`timescale 1ns/100ps
`include "tap_defs.vh"

module tb;
    localparam [31:0] ID = 32'hA5C3_0F01; // Arbitrary identification value
    reg clk = 1'h0;
    reg resetn = 1'h0;
    reg [69:0] ring = {6'h2D, 64'hF0E1_D2C3_B4A5_9687};
    wire tck, tms, tdi, tdo, tdo_oe, dq_hiz_force;
    wire [3:0] tap_state;
    wire [2:0] ir_active;
    integer err_count = 0;
    integer compares = 0;
    integer cyc = 0;
    logic q;
    logic [69:0] d;
    always #50 clk = ~clk;
    tap_ctrl #(.ID_VALUE(ID)) dut (.clk(clk), .resetn(resetn), .tck(tck), .tms(tms),
        .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .ring_in(ring), .dq_hiz_force(dq_hiz_force),
        .tap_state(tap_state), .ir_active(ir_active));
    jtag_tester host (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
    ////////////////////////////////////////////////////////////////////////////////
    task check(input string name, input logic [69:0] exp, input logic [69:0] got);
    begin
        compares = compares + 1;
        if (got !== exp)
        begin
            err_count = err_count + 1;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    end
    endtask
    // Idle to idle through one scan; tdi toggles in non-shift steps to show it is ignored
    task scan(input logic ir, input integer n, input logic [69:0] din);
        integer i;
    begin
        host.step(1'h1, 1'h1, q);
        if (ir)
            host.step(1'h1, 1'h0, q);
        host.step(1'h0, 1'h1, q);
        host.step(1'h0, 1'h0, q);
        for (i = 0; i < n; i = i + 1)
        begin
            check("oe", 70'h1, tdo_oe);
            host.step(i == n - 1, din[i], q);
            d[i] = q;
        end
        host.step(1'h1, 1'h0, q);
        host.step(1'h0, 1'h1, q);
    end
    endtask
    task load_ir(input logic [2:0] code);
    begin
        d = 70'h0;
        scan(1'h1, 3, {67'h0, code});
        check("ir capture", `IR_CAPTURE, d[2:0]);
        check("ir active", code, ir_active);
    end
    endtask
    task close_out;
    begin
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios in order; each ends in the idle state except the five-ones test, which ends in reset
    task test_reset_id;
    begin
        check("state", `ST_RESET, tap_state);
        check("instr", `INS_IDCODE, ir_active);
        host.step(1'h0, 1'h1, q);
        d = 70'h0;
        scan(1'h0, 32, 70'h0);
        check("idcode", ID, d[31:0]);
        $display("test reset and id done");
    end
    endtask
    task test_bypass;
    begin
        load_ir(`INS_BYPASS);
        scan(1'h0, 8, 70'hB4);
        check("bypass", 70'h68, d[7:0]);
        $display("test bypass done");
    end
    endtask
    // Ring levels change between captures, so a stale capture shows up
    task test_sample;
    begin
        load_ir(`INS_SAMPLE);
        check("hiz", 70'h0, dq_hiz_force);
        scan(1'h0, 70, 70'h0);
        check("sample", ring, d);
        ring = ~ring;
        load_ir(`INS_SAMPLEZ);
        check("hiz", 70'h1, dq_hiz_force);
        scan(1'h0, 70, 70'h0);
        check("sample z", ring, d);
        ring = {ring[34:0], ring[69:35]};
        load_ir(`INS_EXTEST);
        check("hiz", 70'h0, dq_hiz_force);
        scan(1'h0, 70, 70'h0);
        check("extest", ring, d);
        $display("test sample done");
    end
    endtask
    // Slow test clock; four ones must not reset, the fifth must
    task test_five_ones;
    begin
        host.half = 8;
        host.step(1'h1, 1'h0, q);
        host.step(1'h0, 1'h1, q);
        host.step(1'h0, 1'h0, q);
        repeat (4) host.step(1'h1, 1'h1, q);
        check("four ones", `ST_SEL_IR, tap_state);
        check("oe idle", 70'h0, tdo_oe);
        host.step(1'h1, 1'h0, q);
        check("five ones", `ST_RESET, tap_state);
        repeat (3) @(negedge clk);
        check("instr", `INS_IDCODE, ir_active);
        check("hiz", 70'h0, dq_hiz_force);
        $display("test five ones done");
    end
    endtask
    initial
    begin
        repeat (20) @(negedge clk);
        resetn = 1'h1;
        @(negedge clk);
        test_reset_id;
        test_bypass;
        test_sample;
        test_five_ones;
        close_out;
    end
    // Hang guard
    always @(posedge clk)
    begin
        cyc = cyc + 1;
        if (cyc == 10000)
        begin
            err_count = err_count + 1;
            close_out;
        end
    end
endmodule
